// ==== cfg_reg.sv ====
// one byte-wide settings register with implemented-bit mask
// assumes write strobe and data come from logic on the same clock
`timescale 1ns/100ps
module cfg_reg #(
	parameter logic [7:0] RESET = 8'h00,
	parameter logic [7:0] BITS = 8'hFF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] q
);

	logic [7:0] q_ff;
	logic [7:0] nxt_q;

	// unimplemented bits never store and read as zero
	always_comb
	begin
		nxt_q = q_ff;
		if (wr_en)
		begin
			nxt_q = wr_data & BITS;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q_ff <= RESET & BITS;
		end
		else
		begin
			q_ff <= nxt_q;
		end
	end

	assign q = q_ff;

endmodule

// ==== limit_cmp.sv ====
// registered comparison of a monitored word against a limit
// assumes both words come from logic on the same clock
`timescale 1ns/100ps
module limit_cmp #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] value,
	input wire logic [WIDTH-1:0] limit,
	output logic over
);

	logic over_ff;
	logic nxt_over;

	// flag follows the level, set while the value is above the limit
	always_comb
	begin
		nxt_over = (value > limit);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			over_ff <= 1'b0;
		end
		else
		begin
			over_ff <= nxt_over;
		end
	end

	assign over = over_ff;

endmodule

// ==== tuning_host.sv ====
// host model driving byte accesses into the register bank
// assumes the bench calls wr and rd from one process
`timescale 1ns/100ps
module tuning_host (
	input wire logic clk,
	output logic [7:0] cmd,
	output logic sel,
	output logic wstb,
	output logic [7:0] wdat,
	output logic rstb,
	input wire logic [7:0] rdat,
	input wire logic rvld
);
	initial
	begin
		cmd = 8'h5A;
		sel = 1'b0;
		wstb = 1'b0;
		wdat = 8'hA5;
		rstb = 1'b0;
	end
	task automatic wr(input logic [7:0] c, input logic s,
		input logic [7:0] d);
		@(negedge clk);
		cmd = c;
		sel = s;
		wdat = d;
		wstb = 1'b1;
		@(negedge clk);
		wstb = 1'b0;
		cmd = ~c;
		wdat = ~d;
	endtask
	task automatic rd(input logic [7:0] c, input logic s,
		output logic [8:0] q);
		@(negedge clk);
		cmd = c;
		sel = s;
		rstb = 1'b1;
		@(negedge clk);
		rstb = 1'b0;
		cmd = ~c;
		q = {rvld, rdat};
	endtask
endmodule

// ==== tuning_pkg.sv ====
// shared constants and types of the regulator tuning register bank
// assumes a byte-wide command interface from the serial bus engine
package tuning_pkg;

	// ****************************************************
	// command codes
	// ****************************************************
	localparam logic [7:0] LOAD_LINE_OFS = 8'hDF;
	localparam logic [7:0] GOOD_HIGH_OFS = 8'hE0;
	localparam logic [7:0] GOOD_LOW_OFS = 8'hE1;
	localparam logic [7:0] CLIMIT_OFS = 8'hE2;
	localparam logic [3:0][7:0] BALANCE_OFS = {8'hE6, 8'hE5, 8'hE4, 8'hE3};
	localparam logic [7:0] MON_FAULT_OFS = 8'hF5;
	localparam logic [7:0] MON_WARN_OFS = 8'hF6;
	localparam logic [7:0] ALERT_MASK_OFS = 8'hF9;

	// ****************************************************
	// reset values
	// ****************************************************
	localparam logic [7:0] LOAD_LINE_RST = 8'h00;
	localparam logic [7:0] GOOD_HIGH_RST = 8'h00;
	localparam logic [7:0] GOOD_LOW_RST = 8'h00;
	localparam logic [7:0] CLIMIT_RST = 8'h10;
	localparam logic [7:0] BALANCE_RST = 8'h10;
	localparam logic [15:0] MON_LIMIT_RST = 16'h0002;
	localparam logic [7:0] ALERT_MASK_RST = 8'h00;

	// ****************************************************
	// implemented bits of each register
	// ****************************************************
	localparam logic [7:0] CODE5_BITS = 8'h1F;
	localparam logic [7:0] GOOD_HIGH_BITS = 8'h03;
	localparam logic [7:0] GOOD_LOW_BITS = 8'h07;
	localparam logic [7:0] FULL_BITS = 8'hFF;
	localparam logic [7:0] ALERT_MASK_BITS = 8'hCD;

	// ****************************************************
	// alert mask fields
	// ****************************************************
	localparam int VOUT_GATE_BIT = 7;
	localparam int IOUT_GATE_BIT = 6;
	localparam int CML_GATE_BIT = 3;
	localparam int MON_GATE_BIT = 2;
	localparam int POUT_GATE_BIT = 0;

	// ****************************************************
	// decode figures: thresholds in millivolts, load-line in permille
	// ****************************************************
	localparam logic [8:0] GOOD_HIGH_TOP_MV = 9'h12C;
	localparam logic [8:0] GOOD_HIGH_STEP_MV = 9'h032;
	localparam logic signed [9:0] GOOD_LOW_BASE_MV = -10'sd500;
	localparam logic signed [9:0] GOOD_LOW_STEP_MV = 10'sd50;
	localparam logic [9:0] LOAD_LINE_FULL = 10'h3E8;
	localparam logic [9:0] LOAD_LINE_STEPS = 10'h01F;

	// status sources that may raise the alert output
	typedef struct packed {
		logic [7:0] out_voltage;
		logic [7:0] out_current;
		logic [7:0] comms_logic;
		logic out_power_over;
	} status_src_t;

endpackage

// ==== tuning_regs.sv ====
// register bank of the regulator tuning settings and alert masking
// assumes the serial bus engine presents decoded byte accesses on
// REF_CLK and that status sources are on the same clock
`timescale 1ns/100ps

// Summary of operation
// - a five-bit load-line code raises the load-line 3.226% per step.
// - the load-line code spans none to full in 31 steps and resets to 0.
// - load-line codes 0, 16 and 31 give none, 51.613% and full.
// - one two-bit code sets good-high: 300/250/200/150 mV.
// - a three-bit good-low code gives -500 mV plus 50 mV per step.
// - the current-limit code scales the external limit, not replaces it.
// - the current-limit code moves 3.33% per step from 46.7% to 150%.
// - current-limit code 16 is 100% and is the reset value.
// - four phase-balance gain codes exist, each resetting to 16.
// - each balance code sets gain 3.75 at code 0 to 6.25 at code 31.
// - mask bit 7 gates voltage and bit 6 current status off the alert.
// - mask bit 3 gates communication and logic status off the alert.
// - mask bit 2 gates monitored-voltage limit events off the alert.
// - mask bit 0 gates output power over limit off the alert.
module tuning_regs (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic [7:0] CMD_CODE,
	input wire logic BYTE_SEL,
	input wire logic WR_STB,
	input wire logic [7:0] WR_DATA,
	input wire logic RD_STB,
	output logic [7:0] RD_DATA,
	output logic RD_VALID,
	output logic CMD_HIT,
	input wire tuning_pkg::status_src_t STATUS_IN,
	input wire logic [15:0] MON_VOLTAGE,
	output logic [4:0] LOAD_LINE_CODE,
	output logic [9:0] LOAD_LINE_PERMILLE,
	output logic [1:0] GOOD_HIGH_CODE,
	output logic [8:0] GOOD_HIGH_MV,
	output logic [2:0] GOOD_LOW_CODE,
	output logic signed [9:0] GOOD_LOW_MV,
	output logic [4:0] CLIMIT_CODE,
	output logic [19:0] BALANCE_CODE,
	output logic MON_FAULT,
	output logic MON_WARN,
	output logic ALERT_N
);

	// ****************************************************
	// write decode
	// ****************************************************
	logic wr_low;
	logic wr_high;

	assign wr_low = WR_STB && !BYTE_SEL;
	assign wr_high = WR_STB && BYTE_SEL;

	logic [7:0] load_line_q;
	logic [7:0] good_high_q;
	logic [7:0] good_low_q;
	logic [7:0] climit_q;
	logic [3:0][7:0] balance_q;
	logic [3:0][7:0] limit_q;
	logic [7:0] alert_mask_q;

	// ****************************************************
	// settings registers
	// ****************************************************
	cfg_reg #(
		.RESET(tuning_pkg::LOAD_LINE_RST),
		.BITS(tuning_pkg::CODE5_BITS)
	) u_load_line (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.wr_en(wr_low && CMD_CODE == tuning_pkg::LOAD_LINE_OFS),
		.wr_data(WR_DATA),
		.q(load_line_q)
	);
	cfg_reg #(
		.RESET(tuning_pkg::GOOD_HIGH_RST),
		.BITS(tuning_pkg::GOOD_HIGH_BITS)
	) u_good_high (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.wr_en(wr_low && CMD_CODE == tuning_pkg::GOOD_HIGH_OFS),
		.wr_data(WR_DATA),
		.q(good_high_q)
	);
	cfg_reg #(
		.RESET(tuning_pkg::GOOD_LOW_RST),
		.BITS(tuning_pkg::GOOD_LOW_BITS)
	) u_good_low (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.wr_en(wr_low && CMD_CODE == tuning_pkg::GOOD_LOW_OFS),
		.wr_data(WR_DATA),
		.q(good_low_q)
	);
	cfg_reg #(
		.RESET(tuning_pkg::CLIMIT_RST),
		.BITS(tuning_pkg::CODE5_BITS)
	) u_climit (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.wr_en(wr_low && CMD_CODE == tuning_pkg::CLIMIT_OFS),
		.wr_data(WR_DATA),
		.q(climit_q)
	);
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : gen_bal
			cfg_reg #(
				.RESET(tuning_pkg::BALANCE_RST),
				.BITS(tuning_pkg::CODE5_BITS)
			) u_balance (
				.clk(REF_CLK),
				.rst_n(RST_N),
				.wr_en(wr_low && CMD_CODE == tuning_pkg::BALANCE_OFS[g]),
				.wr_data(WR_DATA),
				.q(balance_q[g])
			);
		end
	endgenerate

	// two-byte limits: even index low byte, fault pair then warning pair
	genvar h;
	generate
		for (h = 0; h < 4; h++)
		begin : gen_lim
			cfg_reg #(
				.RESET(tuning_pkg::MON_LIMIT_RST[8 * (h % 2) +: 8]),
				.BITS(tuning_pkg::FULL_BITS)
			) u_limit (
				.clk(REF_CLK),
				.rst_n(RST_N),
				.wr_en((h % 2 == 1 ? wr_high : wr_low) &&
					CMD_CODE == (h < 2 ? tuning_pkg::MON_FAULT_OFS :
					tuning_pkg::MON_WARN_OFS)),
				.wr_data(WR_DATA),
				.q(limit_q[h])
			);
		end
	endgenerate

	cfg_reg #(
		.RESET(tuning_pkg::ALERT_MASK_RST),
		.BITS(tuning_pkg::ALERT_MASK_BITS)
	) u_alert_mask (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.wr_en(wr_low && CMD_CODE == tuning_pkg::ALERT_MASK_OFS),
		.wr_data(WR_DATA),
		.q(alert_mask_q)
	);

	// ****************************************************
	// monitored voltage limit checks
	// ****************************************************
	logic mon_fault;
	logic mon_warn;

	limit_cmp #(.WIDTH(16)) u_fault_cmp (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.value(MON_VOLTAGE),
		.limit({limit_q[1], limit_q[0]}),
		.over(mon_fault)
	);

	limit_cmp #(.WIDTH(16)) u_warn_cmp (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.value(MON_VOLTAGE),
		.limit({limit_q[3], limit_q[2]}),
		.over(mon_warn)
	);

	// ****************************************************
	// read mux
	// ****************************************************
	logic [7:0] rd_mux;
	logic hit;

	always_comb
	begin
		rd_mux = 8'h00;
		hit = 1'b1;
		case (CMD_CODE)
			tuning_pkg::LOAD_LINE_OFS: rd_mux = load_line_q;
			tuning_pkg::GOOD_HIGH_OFS: rd_mux = good_high_q;
			tuning_pkg::GOOD_LOW_OFS: rd_mux = good_low_q;
			tuning_pkg::CLIMIT_OFS: rd_mux = climit_q;
			tuning_pkg::BALANCE_OFS[0]: rd_mux = balance_q[0];
			tuning_pkg::BALANCE_OFS[1]: rd_mux = balance_q[1];
			tuning_pkg::BALANCE_OFS[2]: rd_mux = balance_q[2];
			tuning_pkg::BALANCE_OFS[3]: rd_mux = balance_q[3];
			tuning_pkg::MON_FAULT_OFS: rd_mux = BYTE_SEL ? limit_q[1] : limit_q[0];
			tuning_pkg::MON_WARN_OFS: rd_mux = BYTE_SEL ? limit_q[3] : limit_q[2];
			tuning_pkg::ALERT_MASK_OFS: rd_mux = alert_mask_q;
			default: hit = 1'b0;
		endcase
		// second byte of a one-byte register reads as zero
		if (BYTE_SEL && CMD_CODE != tuning_pkg::MON_FAULT_OFS &&
			CMD_CODE != tuning_pkg::MON_WARN_OFS)
		begin
			rd_mux = 8'h00;
		end
	end

	// ****************************************************
	// alert gating
	// ****************************************************
	logic alert_any;

	always_comb
	begin
		alert_any = 1'b0;
		if (|STATUS_IN.out_voltage && !alert_mask_q[tuning_pkg::VOUT_GATE_BIT])
		begin
			alert_any = 1'b1;
		end
		if (|STATUS_IN.out_current && !alert_mask_q[tuning_pkg::IOUT_GATE_BIT])
		begin
			alert_any = 1'b1;
		end
		if (|STATUS_IN.comms_logic && !alert_mask_q[tuning_pkg::CML_GATE_BIT])
		begin
			alert_any = 1'b1;
		end
		if ((mon_fault || mon_warn) && !alert_mask_q[tuning_pkg::MON_GATE_BIT])
		begin
			alert_any = 1'b1;
		end
		if (STATUS_IN.out_power_over && !alert_mask_q[tuning_pkg::POUT_GATE_BIT])
		begin
			alert_any = 1'b1;
		end
	end

	// ****************************************************
	// decoded settings
	// ****************************************************
	logic [9:0] nxt_ll_permille;
	logic [8:0] nxt_gh_mv;
	logic signed [9:0] nxt_gl_mv;
	logic [19:0] ll_prod;

	always_comb
	begin
		// full load-line spread over 31 codes, 3.226% a step
		ll_prod = 20'(load_line_q[4:0]) * 20'(tuning_pkg::LOAD_LINE_FULL);
		nxt_ll_permille = 10'(ll_prod / 20'(tuning_pkg::LOAD_LINE_STEPS));
		nxt_gh_mv = tuning_pkg::GOOD_HIGH_TOP_MV -
			9'(9'(good_high_q[1:0]) * tuning_pkg::GOOD_HIGH_STEP_MV);
		nxt_gl_mv = tuning_pkg::GOOD_LOW_BASE_MV +
			10'(10'(good_low_q[2:0]) * tuning_pkg::GOOD_LOW_STEP_MV);
	end

	// ****************************************************
	// output registers
	// ****************************************************
	logic [7:0] rd_data_ff;
	logic rd_valid_ff;
	logic cmd_hit_ff;
	logic alert_n_ff;
	logic [9:0] ll_permille_ff;
	logic [8:0] gh_mv_ff;
	logic signed [9:0] gl_mv_ff;
	logic [7:0] nxt_rd_data;
	logic nxt_rd_valid;
	logic nxt_cmd_hit;
	logic nxt_alert_n;

	always_comb
	begin
		nxt_rd_data = rd_data_ff;
		nxt_rd_valid = RD_STB;
		nxt_cmd_hit = cmd_hit_ff;
		nxt_alert_n = !alert_any;
		if (RD_STB)
		begin
			nxt_rd_data = rd_mux;
			nxt_cmd_hit = hit;
		end
		else if (WR_STB)
		begin
			nxt_cmd_hit = hit;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rd_data_ff <= 8'h00;
			rd_valid_ff <= 1'b0;
			cmd_hit_ff <= 1'b0;
			alert_n_ff <= 1'b1;
			ll_permille_ff <= 10'h000;
			gh_mv_ff <= tuning_pkg::GOOD_HIGH_TOP_MV;
			gl_mv_ff <= tuning_pkg::GOOD_LOW_BASE_MV;
		end
		else
		begin
			rd_data_ff <= nxt_rd_data;
			rd_valid_ff <= nxt_rd_valid;
			cmd_hit_ff <= nxt_cmd_hit;
			alert_n_ff <= nxt_alert_n;
			ll_permille_ff <= nxt_ll_permille;
			gh_mv_ff <= nxt_gh_mv;
			gl_mv_ff <= nxt_gl_mv;
		end
	end

	// codes scale external settings; the analog loop applies them
	assign LOAD_LINE_CODE = load_line_q[4:0];
	assign GOOD_HIGH_CODE = good_high_q[1:0];
	assign GOOD_LOW_CODE = good_low_q[2:0];
	assign CLIMIT_CODE = climit_q[4:0];
	assign BALANCE_CODE = {balance_q[3][4:0], balance_q[2][4:0],
		balance_q[1][4:0], balance_q[0][4:0]};
	assign LOAD_LINE_PERMILLE = ll_permille_ff;
	assign GOOD_HIGH_MV = gh_mv_ff;
	assign GOOD_LOW_MV = gl_mv_ff;
	assign MON_FAULT = mon_fault;
	assign MON_WARN = mon_warn;
	assign RD_DATA = rd_data_ff;
	assign RD_VALID = rd_valid_ff;
	assign CMD_HIT = cmd_hit_ff;
	assign ALERT_N = alert_n_ff;

endmodule

// ==== tuning_regs_chk.sv ====
// checker on the ports of the tuning register bank
// assumes it is bound onto tuning_regs, one clock
`timescale 1ns/100ps
module tuning_regs_chk (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic [7:0] CMD_CODE,
	input wire logic BYTE_SEL,
	input wire logic WR_STB,
	input wire logic [7:0] WR_DATA,
	input wire logic RD_STB,
	input wire logic [7:0] RD_DATA,
	input wire logic RD_VALID,
	input wire logic CMD_HIT,
	input wire tuning_pkg::status_src_t STATUS_IN,
	input wire logic [4:0] LOAD_LINE_CODE,
	input wire logic [9:0] LOAD_LINE_PERMILLE,
	input wire logic [1:0] GOOD_HIGH_CODE,
	input wire logic [8:0] GOOD_HIGH_MV,
	input wire logic [2:0] GOOD_LOW_CODE,
	input wire logic signed [9:0] GOOD_LOW_MV,
	input wire logic [4:0] CLIMIT_CODE,
	input wire logic MON_FAULT,
	input wire logic MON_WARN,
	input wire logic ALERT_N
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	// ****
	// settings and decode
	// ****
	a_ll_write: assert property (
		WR_STB && !BYTE_SEL && CMD_CODE == 8'hDF
		|=> LOAD_LINE_CODE == $past(WR_DATA[4:0]))
		else $error("load-line code not stored");
	a_cl_write: assert property (
		WR_STB && !BYTE_SEL && CMD_CODE == 8'hE2
		|=> CLIMIT_CODE == $past(WR_DATA[4:0]))
		else $error("current limit code not stored");
	a_gh_decode: assert property (
		1'b1 |=> GOOD_HIGH_MV == 9'(300 - 50 * int'($past(GOOD_HIGH_CODE))))
		else $error("good high decode wrong");
	a_gl_decode: assert property (
		1'b1 |=> GOOD_LOW_MV == 10'(-500 + 50 * int'($past(GOOD_LOW_CODE))))
		else $error("good low decode wrong");
	a_ll_decode: assert property (
		1'b1 |=> LOAD_LINE_PERMILLE ==
		10'(int'($past(LOAD_LINE_CODE)) * 1000 / 31))
		else $error("load-line decode wrong");
	a_unmapped_read: assert property (
		RD_STB && CMD_CODE == 8'h00
		|=> RD_VALID && RD_DATA == 8'h00 && !CMD_HIT)
		else $error("unmapped read answered");
	// ****
	// alert
	// ****
	a_alert_cause: assert property (
		!ALERT_N |-> $past(|STATUS_IN || MON_FAULT || MON_WARN))
		else $error("alert without a source");
	a_alert_idle: assert property (
		!(|STATUS_IN) && !MON_FAULT && !MON_WARN |=> ALERT_N)
		else $error("alert stays without a source");
	c_mask_write: cover property (WR_STB && CMD_CODE == 8'hF9);
	c_alert_low: cover property ($fell(ALERT_N));
	c_unmapped: cover property (RD_STB && CMD_CODE == 8'h00);
endmodule
bind tuning_regs tuning_regs_chk chk_u (.REF_CLK, .RST_N, .CMD_CODE,
	.BYTE_SEL, .WR_STB, .WR_DATA, .RD_STB, .RD_DATA, .RD_VALID, .CMD_HIT,
	.STATUS_IN, .LOAD_LINE_CODE, .LOAD_LINE_PERMILLE, .GOOD_HIGH_CODE,
	.GOOD_HIGH_MV, .GOOD_LOW_CODE, .GOOD_LOW_MV, .CLIMIT_CODE, .MON_FAULT,
	.MON_WARN, .ALERT_N);

// ==== tuning_regs_tb_top.sv ====
// self-checking bench of the tuning register bank
// assumes tuning_host drives the command port
`timescale 1ns/100ps
module tuning_regs_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] cmd, wdat, rdat, c;
	logic sel, wstb, rstb, rvld, hit, fault, warn, alert_n, s;
	tuning_pkg::status_src_t src = '0;
	logic [15:0] mon = 16'h0000;
	logic [4:0] ll, cl;
	logic [9:0] pm;
	logic [1:0] gh;
	logic [8:0] ghmv, q;
	logic [2:0] gl;
	logic signed [9:0] glmv;
	logic [19:0] bal;
	int n_errors = 0;
	int checks = 0;
	int k;
	int unsigned seed;
	logic [7:0] mdl [int];
	logic [7:0] codes [11] = '{8'hDF, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4,
		8'hE5, 8'hE6, 8'hF5, 8'hF6, 8'hF9};
	logic [7:0] gate [5] = '{8'h80, 8'h40, 8'h08, 8'h01, 8'h04};
	always #5 clk = ~clk;
	tuning_regs dut_u (.REF_CLK(clk), .RST_N(rst_n), .CMD_CODE(cmd),
		.BYTE_SEL(sel), .WR_STB(wstb), .WR_DATA(wdat), .RD_STB(rstb),
		.RD_DATA(rdat), .RD_VALID(rvld), .CMD_HIT(hit), .STATUS_IN(src),
		.MON_VOLTAGE(mon), .LOAD_LINE_CODE(ll), .LOAD_LINE_PERMILLE(pm),
		.GOOD_HIGH_CODE(gh), .GOOD_HIGH_MV(ghmv), .GOOD_LOW_CODE(gl),
		.GOOD_LOW_MV(glmv), .CLIMIT_CODE(cl), .BALANCE_CODE(bal),
		.MON_FAULT(fault), .MON_WARN(warn), .ALERT_N(alert_n));
	tuning_host host_u (.clk(clk), .cmd(cmd), .sel(sel), .wstb(wstb),
		.wdat(wdat), .rstb(rstb), .rdat(rdat), .rvld(rvld));
	function automatic logic [7:0] impl(input logic [7:0] a, input logic b);
		if (b)
			return (a == 8'hF5 || a == 8'hF6) ? 8'hFF : 8'h00;
		case (a)
			8'hE0: return 8'h03;
			8'hE1: return 8'h07;
			8'hF5, 8'hF6: return 8'hFF;
			8'hF9: return 8'hCD;
			8'hDF, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6: return 8'h1F;
			default: return 8'h00;
		endcase
	endfunction
	task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic b, input logic [7:0] d);
		host_u.wr(a, b, d);
		if (impl(a, b) != 8'h00)
			mdl[{a, b}] = d & impl(a, b);
	endtask
	task automatic cmp_rd(input logic [7:0] a, input logic b);
		host_u.rd(a, b, q);
		cmp({11'h000, q}, {12'h001, mdl.exists({a, b}) ? mdl[{a, b}] : 8'h00});
	endtask
	task automatic chk_reset();
		mdl.delete();
		foreach (codes[i])
			mdl[{codes[i], 1'b0}] = (codes[i] inside {[8'hE2:8'hE6]}) ? 8'h10 : 8'h00;
		mdl[9'h1EA] = 8'h02;
		mdl[9'h1EC] = 8'h02;
		foreach (codes[i])
		begin
			cmp_rd(codes[i], 1'b0);
			cmp_rd(codes[i], 1'b1);
		end
		cmp({1'b0, ghmv, glmv}, {10'h12C, -10'sd500});
		cmp(bal, 20'h84210);
		cmp({15'h0000, cl}, 20'h00010);
		cmp({17'h00000, alert_n, fault, warn}, 20'h00004);
		$display("test reset values done");
	endtask
	task automatic end_sim();
		$display("counts: %0d checks, %0d mismatches", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#200000;
		n_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		end_sim();
	end
	initial
	begin
		seed = $urandom(49);
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		chk_reset();
		repeat (60)
		begin
			k = $urandom_range(11, 0);
			c = (k < 11) ? codes[k % 11] : 8'h00;
			s = 1'($urandom);
			wr(c, s, 8'($urandom));
			cmp_rd(c, s);
			cmp({19'h00000, hit}, {19'h00000, k < 11});
		end
		cmp({5'h00, ll, cl, gh, gl}, {5'h00, mdl[9'h1BE][4:0], mdl[9'h1C4][4:0],
			mdl[9'h1C0][1:0], mdl[9'h1C2][2:0]});
		cmp(bal, {mdl[9'h1CC][4:0], mdl[9'h1CA][4:0], mdl[9'h1C8][4:0],
			mdl[9'h1C6][4:0]});
		$display("test register access done");
		for (int i = 0; i < 32; i++)
		begin
			wr(8'hDF, 1'b0, 8'(i));
			wr(8'hE0, 1'b0, 8'(i));
			wr(8'hE1, 1'b0, 8'(i));
			@(negedge clk);
			cmp({10'h000, pm}, 20'(i * 1000 / 31));
			cmp({1'b0, ghmv, glmv}, {1'b0, 9'(300 - 50 * (i % 4)),
				10'(-500 + 50 * (i % 8))});
		end
		$display("test decode sweep done");
		wr(8'hF5, 1'b0, 8'h34);
		wr(8'hF5, 1'b1, 8'h12);
		wr(8'hF6, 1'b0, 8'h34);
		wr(8'hF6, 1'b1, 8'h12);
		mon = 16'h1234;
		repeat (3) @(negedge clk);
		cmp({18'h00000, fault, warn}, 20'h00000);
		for (int j = 0; j < 10; j++)
		begin
			wr(8'hF9, 1'b0, j[0] ? gate[j / 2] : ~gate[j / 2]);
			case (j / 2)
				0: src.out_voltage = 8'h01 << $urandom_range(7, 0);
				1: src.out_current = 8'h01 << $urandom_range(7, 0);
				2: src.comms_logic = 8'h01 << $urandom_range(7, 0);
				3: src.out_power_over = 1'b1;
				default: mon = 16'h1235;
			endcase
			repeat (3) @(negedge clk);
			cmp({17'h00000, alert_n, fault, warn}, {17'h00000, j[0], j >= 8, j >= 8});
			src = '0;
			mon = 16'h1234;
			repeat (3) @(negedge clk);
			cmp({19'h00000, alert_n}, 20'h00001);
		end
		$display("test alert gating done");
		mon = 16'h0000;
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		chk_reset();
		end_sim();
	end
endmodule
